// ### rtl/cmo_message_objects.sv
// CAN message objects, acceptance filtering and auxiliary port
// Function
// - Fifteen objects, eight data bytes each
// - Own identifier and direction, last fixed
// - Last object receive-only with own mask
// - Receive object request sends remote frame
// - Transmit object answers matching remote frame
// - Per-object transmit and receive status bits
// - Global mask marks identifier bits don't-care
// - Separate standard and extended global masks
// - Global mask then objects one to fourteen
// - No match: try last object's local mask
// - Last object double buffered for host
// - Port bits 0-1 lamps or user lines
// - Serial memory target address select 000
// - Serial memory holds 256 user bytes
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cmo_message_objects
  import cmo_pkg::*;
#(
  parameter int NUM_OBJ = OBJ_COUNT
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxValid,
  input wire cmo_frame_t rxFrame,
  output logic txValid,
  output cmo_frame_t txFrame,
  input wire logic txDone,
  input wire logic [7:0] auxIn,
  output logic [7:0] auxOut,
  output logic [7:0] auxOe,
  output logic irq
);
  localparam int LAST = NUM_OBJ - 1;
  localparam logic [3:0] LAST_IDX = 4'(LAST);

  if (NUM_OBJ < 2 || NUM_OBJ > 16) begin : g_chk
    $error("NUM_OBJ must lie between 2 and 16");
  end

  // Bus-side registers
  logic ctrlLamp_r, ctrlLamp_nxt;
  logic [7:0] auxOutReg_r, auxOutReg_nxt, auxDir_r, auxDir_nxt;
  logic [STD_W-1:0] gMaskStd_r, gMaskStd_nxt;
  logic [ID_W-1:0] gMaskExt_r, gMaskExt_nxt, maskLast_r, maskLast_nxt;
  logic [3:0] objSel_r, objSel_nxt;
  logic [31:0] intMask_r, intMask_nxt;
  logic [31:0] prdata_r, prdata_nxt, rdData;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, rdErr;
  // Object storage and status
  cmo_obj_t objs_r [NUM_OBJ];
  cmo_obj_t objs_nxt [NUM_OBJ];
  logic [NUM_OBJ-1:0] txReq_r, txReq_nxt, txSet, txClr;
  logic [31:0] intStat_r, intStat_nxt, statSet, statClr;
  cmo_frame_t shadow_r, shadow_nxt;
  logic shadowFull_r, shadowFull_nxt, overrun_r, overrun_nxt, lastFree;
  logic [ID_W-1:0] lastRxId_r, lastRxId_nxt;
  // Transmit engine
  cmo_txst_t txState_r, txState_nxt;
  logic [3:0] txIdx_r, txIdx_nxt, pickIdx;
  logic txValid_r, txValid_nxt;
  cmo_frame_t txFrame_r, txFrame_nxt;
  // Pins and interrupt
  logic [7:0] auxO_r, auxO_nxt, auxOe_r, auxOe_nxt;
  logic irq_r, irq_nxt;
  // Decode
  logic apbWr, apbSetup, selOk;
  logic [3:0] selIdx;
  logic fHit, fHitLast;
  logic [3:0] fHitIdx;

  // Lowest requesting object
  function automatic logic [3:0] lowestSet(logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // Bus strobes and object window selection
  assign apbWr = psel & penable & pready_r & pwrite;
  assign apbSetup = psel & ~penable;
  assign selOk = {1'b0, objSel_r} < 5'(NUM_OBJ);
  assign selIdx = selOk ? objSel_r : 4'h0;
  assign pickIdx = lowestSet(16'(txReq_r));

  cmo_acc_filter #(
    .NUM_OBJ(NUM_OBJ)
  ) u_filter (
    .frame(rxFrame),
    .objs(objs_r),
    .gMaskStd(gMaskStd_r),
    .gMaskExt(gMaskExt_r),
    .maskLast(maskLast_r),
    .hit(fHit),
    .hitIdx(fHitIdx),
    .hitLast(fHitLast)
  );

  // Read mux, error flag and plain register writes
  always_comb begin
    ctrlLamp_nxt = ctrlLamp_r;
    auxOutReg_nxt = auxOutReg_r;
    auxDir_nxt = auxDir_r;
    gMaskStd_nxt = gMaskStd_r;
    gMaskExt_nxt = gMaskExt_r;
    maskLast_nxt = maskLast_r;
    objSel_nxt = objSel_r;
    intMask_nxt = intMask_r;
    prdata_nxt = prdata_r;
    pready_nxt = apbSetup;
    pslverr_nxt = 1'b0;
    rdErr = 1'b0;
    rdData = 32'h00000000;
    case (paddr)
      ADDR_CTRL: rdData = {31'h0, ctrlLamp_r};
      ADDR_AUX_OUT: rdData = {24'h0, auxOutReg_r};
      ADDR_AUX_DIR: rdData = {24'h0, auxDir_r};
      ADDR_AUX_IN: rdData = {24'h0, auxIn};
      ADDR_GMASK_STD: rdData = {21'h0, gMaskStd_r};
      ADDR_GMASK_EXT: rdData = {3'h0, gMaskExt_r};
      ADDR_MASK_LAST: rdData = {3'h0, maskLast_r};
      ADDR_OBJ_SEL: rdData = {28'h0, objSel_r};
      ADDR_OBJ_ID: rdData = {objs_r[selIdx].ext, 2'h0, objs_r[selIdx].id};
      ADDR_OBJ_CTRL: rdData = {24'h0, objs_r[selIdx].dlc, 1'b0,
                               txReq_r[selIdx], objs_r[selIdx].dirTx,
                               objs_r[selIdx].valid};
      ADDR_OBJ_DLO: rdData = objs_r[selIdx].data[31:0];
      ADDR_OBJ_DHI: rdData = objs_r[selIdx].data[63:32];
      ADDR_INT_STAT: rdData = intStat_r;
      ADDR_INT_MASK: rdData = intMask_r;
      ADDR_LAST_STAT: rdData = {30'h0, overrun_r, shadowFull_r};
      ADDR_LAST_ID: rdData = {3'h0, lastRxId_r};
      default: rdErr = 1'b1;
    endcase
    if (apbSetup) begin
      prdata_nxt = rdData;
      pslverr_nxt = rdErr;
    end
    if (apbWr) begin
      case (paddr)
        ADDR_CTRL: ctrlLamp_nxt = pwdata[CTRL_LAMP_BIT];
        ADDR_AUX_OUT: auxOutReg_nxt = pwdata[7:0];
        ADDR_AUX_DIR: auxDir_nxt = pwdata[7:0];
        ADDR_GMASK_STD: gMaskStd_nxt = pwdata[STD_W-1:0];
        ADDR_GMASK_EXT: gMaskExt_nxt = pwdata[ID_W-1:0];
        ADDR_MASK_LAST: maskLast_nxt = pwdata[ID_W-1:0];
        ADDR_OBJ_SEL: objSel_nxt = pwdata[3:0];
        ADDR_INT_MASK: intMask_nxt = pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlLamp_r <= 1'b0;
      auxOutReg_r <= AUX_OUT_RST;
      auxDir_r <= AUX_DIR_RST;
      gMaskStd_r <= GMASK_STD_RST;
      gMaskExt_r <= GMASK_EXT_RST;
      maskLast_r <= MASK_LAST_RST;
      objSel_r <= 4'h0;
      intMask_r <= INT_MASK_RST;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrlLamp_r <= ctrlLamp_nxt;
      auxOutReg_r <= auxOutReg_nxt;
      auxDir_r <= auxDir_nxt;
      gMaskStd_r <= gMaskStd_nxt;
      gMaskExt_r <= gMaskExt_nxt;
      maskLast_r <= maskLast_nxt;
      objSel_r <= objSel_nxt;
      intMask_r <= intMask_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Object contents, requests, sticky status and last-object buffer
  always_comb begin
    objs_nxt = objs_r;
    shadow_nxt = shadow_r;
    shadowFull_nxt = shadowFull_r;
    overrun_nxt = overrun_r;
    lastRxId_nxt = lastRxId_r;
    txSet = '0;
    txClr = '0;
    statSet = 32'h00000000;
    statClr = 32'h00000000;
    if (apbWr && selOk) begin
      case (paddr)
        ADDR_OBJ_ID: begin
          objs_nxt[selIdx].ext = pwdata[OID_EXT_BIT];
          objs_nxt[selIdx].id = pwdata[ID_W-1:0];
        end
        ADDR_OBJ_CTRL: begin
          objs_nxt[selIdx].valid = pwdata[OCTL_VALID_BIT];
          objs_nxt[selIdx].dirTx = pwdata[OCTL_DIR_BIT] &&
                                   (selIdx != LAST_IDX);
          objs_nxt[selIdx].dlc = pwdata[OCTL_DLC_LSB+:4];
          if (pwdata[OCTL_TXREQ_BIT] && selIdx != LAST_IDX) begin
            txSet[selIdx] = 1'b1;
          end
        end
        ADDR_OBJ_DLO: objs_nxt[selIdx].data[31:0] = pwdata;
        ADDR_OBJ_DHI: objs_nxt[selIdx].data[63:32] = pwdata;
        default: ;
      endcase
    end
    if (apbWr && paddr == ADDR_INT_STAT) begin
      statClr = pwdata;
    end
    if (apbWr && paddr == ADDR_LAST_STAT && pwdata[LAST_OVR_BIT]) begin
      overrun_nxt = 1'b0;
    end
    // Matched frames for objects other than the last
    if (rxValid && fHit) begin
      if (rxFrame.rtr) begin
        txSet[fHitIdx] = 1'b1;
      end else begin
        objs_nxt[fHitIdx].dlc = rxFrame.dlc;
        objs_nxt[fHitIdx].data = rxFrame.data;
        statSet[fHitIdx] = 1'b1;
      end
    end
    // Transmit completion
    if (txState_r == TX_BUSY && txDone) begin
      txClr[txIdx_r] = 1'b1;
      statSet[STAT_TX_LSB + int'(txIdx_r)] = 1'b1;
    end
    // Last object: promote the held frame once the host frees the slot
    lastFree = !intStat_r[LAST] || statClr[LAST];
    if (lastFree && shadowFull_r) begin
      objs_nxt[LAST].dlc = shadow_r.dlc;
      objs_nxt[LAST].data = shadow_r.data;
      lastRxId_nxt = shadow_r.id;
      statSet[LAST] = 1'b1;
      shadowFull_nxt = 1'b0;
      lastFree = 1'b0;
    end
    if (rxValid && fHitLast) begin
      if (lastFree) begin
        objs_nxt[LAST].dlc = rxFrame.dlc;
        objs_nxt[LAST].data = rxFrame.data;
        lastRxId_nxt = rxFrame.id;
        statSet[LAST] = 1'b1;
      end else begin
        overrun_nxt = overrun_nxt | shadowFull_nxt;
        shadow_nxt = rxFrame;
        shadowFull_nxt = 1'b1;
      end
    end
    // Set wins over a clear in the same cycle
    txReq_nxt = (txReq_r & ~txClr) | txSet;
    intStat_nxt = (intStat_r & ~statClr) | statSet;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      objs_r <= '{default: '0};
      txReq_r <= '0;
      intStat_r <= 32'h00000000;
      shadow_r <= '0;
      shadowFull_r <= 1'b0;
      overrun_r <= 1'b0;
      lastRxId_r <= '0;
    end else begin
      objs_r <= objs_nxt;
      txReq_r <= txReq_nxt;
      intStat_r <= intStat_nxt;
      shadow_r <= shadow_nxt;
      shadowFull_r <= shadowFull_nxt;
      overrun_r <= overrun_nxt;
      lastRxId_r <= lastRxId_nxt;
    end
  end

  // Transmit engine: one frame in flight, lowest object first
  always_comb begin
    txState_nxt = txState_r;
    txIdx_nxt = txIdx_r;
    txValid_nxt = txValid_r;
    txFrame_nxt = txFrame_r;
    unique case (txState_r)
      TX_IDLE: begin
        if (|txReq_r) begin
          txIdx_nxt = pickIdx;
          txFrame_nxt.ext = objs_r[pickIdx].ext;
          txFrame_nxt.id = objs_r[pickIdx].id;
          txFrame_nxt.rtr = !objs_r[pickIdx].dirTx;
          txFrame_nxt.dlc = objs_r[pickIdx].dlc;
          txFrame_nxt.data = objs_r[pickIdx].data;
          txValid_nxt = 1'b1;
          txState_nxt = TX_BUSY;
        end
      end
      TX_BUSY: begin
        if (txDone) begin
          txValid_nxt = 1'b0;
          txState_nxt = TX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txState_r <= TX_IDLE;
      txIdx_r <= 4'h0;
      txValid_r <= 1'b0;
      txFrame_r <= '0;
    end else begin
      txState_r <= txState_nxt;
      txIdx_r <= txIdx_nxt;
      txValid_r <= txValid_nxt;
      txFrame_r <= txFrame_nxt;
    end
  end

  // Auxiliary port drive and interrupt level
  always_comb begin
    auxO_nxt = auxOutReg_r;
    auxOe_nxt = auxDir_r;
    if (ctrlLamp_r) begin
      auxO_nxt[AUX_LAMP_A] = |intStat_r;
      auxO_nxt[AUX_LAMP_B] = txValid_r;
      auxOe_nxt[AUX_LAMP_B:AUX_LAMP_A] = 2'h3;
    end
    // Serial lines are open drain: drive low or release
    auxO_nxt[AUX_DATA:AUX_CLK] = 2'h0;
    auxOe_nxt[AUX_CLK] = !auxOutReg_r[AUX_CLK];
    auxOe_nxt[AUX_DATA] = !auxOutReg_r[AUX_DATA];
    irq_nxt = |(intStat_r & intMask_r);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      auxO_r <= 8'h00;
      auxOe_r <= 8'h00;
      irq_r <= 1'b0;
    end else begin
      auxO_r <= auxO_nxt;
      auxOe_r <= auxOe_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign txValid = txValid_r;
  assign txFrame = txFrame_r;
  assign auxOut = auxO_r;
  assign auxOe = auxOe_r;
  assign irq = irq_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  lastRx_only_a: assert property (!objs_r[LAST].dirTx && !txReq_r[LAST])
    else $error("last object took a transmit role");
  remote_req_a: assert property ($rose(txValid_r) |->
    txFrame_r.rtr == !objs_r[txIdx_r].dirTx && txFrame_r.id == objs_r[txIdx_r].id)
    else $error("transmit frame type does not follow direction");
  auto_reply_a: assert property (rxValid && rxFrame.rtr && fHit &&
    txState_r == TX_IDLE |=> txReq_r[$past(fHitIdx)] || txValid_r)
    else $error("remote frame did not schedule a reply");
  rx_status_a: assert property (rxValid && !rxFrame.rtr && fHit |=>
    intStat_r[$past(fHitIdx)] && objs_r[$past(fHitIdx)].data == $past(rxFrame.data))
    else $error("received frame not stored or flagged");
  tx_status_a: assert property (txState_r == TX_BUSY && txDone |=>
    intStat_r[STAT_TX_LSB + int'($past(txIdx_r))] && !txValid_r)
    else $error("transmit completion not flagged");
  filter_order_a: assert property (rxValid && fHitLast |->
    (!fHit && !rxFrame.rtr) ##1 (intStat_r[LAST] || shadowFull_r))
    else $error("last object missed or matched out of order");
  last_buffer_a: assert property (rxValid && fHitLast && intStat_r[LAST] &&
    !shadowFull_r && !(apbWr && paddr == ADDR_INT_STAT) |=> shadowFull_r ##1
    shadowFull_r || intStat_r[LAST])
    else $error("second frame for last object was lost");
  lamp_drive_a: assert property (ctrlLamp_r |=> auxOe_r[1:0] == 2'h3)
    else $error("lamp lines not driven in lamp mode");
  serial_od_a: assert property (auxO_r[AUX_DATA:AUX_CLK] == 2'h0 &&
    (auxOe_r[AUX_CLK] == !$past(auxOutReg_r[AUX_CLK]) || !$past(rst_b)))
    else $error("serial line driven high");
  user_dir_a: assert property (##1 auxOe_r[7:4] == $past(auxDir_r[7:4]))
    else $error("user line direction not applied");
endmodule
`default_nettype wire

// ### rtl/cmo_pkg.sv
// Shared constants and types for the CAN message object block
package cmo_pkg;
  // Object storage geometry
  localparam int OBJ_COUNT = 15;
  localparam int DATA_BYTES = 8;
  localparam int ID_W = 29;
  localparam int STD_W = 11;
  localparam int STAT_TX_LSB = 16;
  // External configuration memory on the serial lines
  localparam int CFG_MEM_BYTES = 256;
  localparam logic [2:0] CFG_MEM_ADDR_SEL = 3'h0;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_AUX_OUT = 8'h04;
  localparam logic [7:0] ADDR_AUX_DIR = 8'h08;
  localparam logic [7:0] ADDR_AUX_IN = 8'h0C;
  localparam logic [7:0] ADDR_GMASK_STD = 8'h10;
  localparam logic [7:0] ADDR_GMASK_EXT = 8'h14;
  localparam logic [7:0] ADDR_MASK_LAST = 8'h18;
  localparam logic [7:0] ADDR_OBJ_SEL = 8'h1C;
  localparam logic [7:0] ADDR_OBJ_ID = 8'h20;
  localparam logic [7:0] ADDR_OBJ_CTRL = 8'h24;
  localparam logic [7:0] ADDR_OBJ_DLO = 8'h28;
  localparam logic [7:0] ADDR_OBJ_DHI = 8'h2C;
  localparam logic [7:0] ADDR_INT_STAT = 8'h30;
  localparam logic [7:0] ADDR_INT_MASK = 8'h34;
  localparam logic [7:0] ADDR_LAST_STAT = 8'h38;
  localparam logic [7:0] ADDR_LAST_ID = 8'h3C;
  // Field positions
  localparam int CTRL_LAMP_BIT = 0;
  localparam int OCTL_VALID_BIT = 0;
  localparam int OCTL_DIR_BIT = 1;
  localparam int OCTL_TXREQ_BIT = 2;
  localparam int OCTL_DLC_LSB = 4;
  localparam int OID_EXT_BIT = 31;
  localparam int LAST_SHADOW_BIT = 0;
  localparam int LAST_OVR_BIT = 1;
  localparam int AUX_LAMP_A = 0;
  localparam int AUX_LAMP_B = 1;
  localparam int AUX_CLK = 2;
  localparam int AUX_DATA = 3;
  // Reset values
  localparam logic [STD_W-1:0] GMASK_STD_RST = 11'h7FF;
  localparam logic [ID_W-1:0] GMASK_EXT_RST = 29'h1FFFFFFF;
  localparam logic [ID_W-1:0] MASK_LAST_RST = 29'h1FFFFFFF;
  localparam logic [7:0] AUX_OUT_RST = 8'h0C;
  localparam logic [7:0] AUX_DIR_RST = 8'h00;
  localparam logic [31:0] INT_MASK_RST = 32'h00000000;

  // Frame as seen by the protocol engine
  typedef struct packed {
    logic ext;
    logic rtr;
    logic [ID_W-1:0] id;
    logic [3:0] dlc;
    logic [8*DATA_BYTES-1:0] data;
  } cmo_frame_t;

  // One message object
  typedef struct packed {
    logic valid;
    logic dirTx;
    logic ext;
    logic [ID_W-1:0] id;
    logic [3:0] dlc;
    logic [8*DATA_BYTES-1:0] data;
  } cmo_obj_t;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_BUSY = 1'b1
  } cmo_txst_t;
endpackage

// ### rtl/cmo_acc_filter.sv
// Acceptance filter: global masks, objects 1..n-1, then the last object
`timescale 1ns/100ps
`default_nettype none
module cmo_acc_filter
  import cmo_pkg::*;
#(
  parameter int NUM_OBJ = OBJ_COUNT
) (
  input wire cmo_frame_t frame,
  input wire cmo_obj_t objs [NUM_OBJ],
  input wire logic [STD_W-1:0] gMaskStd,
  input wire logic [ID_W-1:0] gMaskExt,
  input wire logic [ID_W-1:0] maskLast,
  output logic hit,
  output logic [3:0] hitIdx,
  output logic hitLast
);
  logic [ID_W-1:0] effMask;
  logic [NUM_OBJ-2:0] cand;

  // Index output is four bits wide
  if (NUM_OBJ < 2 || NUM_OBJ > 16) begin : g_chk
    $error("NUM_OBJ must lie between 2 and 16");
  end

  // Masked identifier compare; a clear mask bit is don't-care
  function automatic logic idMatch(logic [ID_W-1:0] a, logic [ID_W-1:0] b,
                                   logic [ID_W-1:0] m, logic ext);
    if (ext) begin
      return ((a ^ b) & m) == '0;
    end
    return ((a[STD_W-1:0] ^ b[STD_W-1:0]) & m[STD_W-1:0]) == '0;
  endfunction

  // Global mask chosen by frame format
  assign effMask = frame.ext ? gMaskExt : {{(ID_W-STD_W){1'b0}}, gMaskStd};

  // Candidates among all but the last object
  for (genvar i = 0; i < NUM_OBJ - 1; i++) begin : g_cand
    assign cand[i] = objs[i].valid && (objs[i].ext == frame.ext) &&
                     (frame.rtr == objs[i].dirTx) &&
                     idMatch(frame.id, objs[i].id, effMask, frame.ext);
  end

  // Lowest index wins; the last object only catches leftovers
  always_comb begin
    hit = |cand;
    hitIdx = 4'h0;
    for (int i = NUM_OBJ - 2; i >= 0; i--) begin
      if (cand[i]) begin
        hitIdx = 4'(i);
      end
    end
    hitLast = !hit && !frame.rtr && objs[NUM_OBJ-1].valid &&
              (objs[NUM_OBJ-1].ext == frame.ext) &&
              idMatch(frame.id, objs[NUM_OBJ-1].id, effMask & maskLast,
                      frame.ext);
  end
endmodule
`default_nettype wire

// ### verification/cmo_can_node.sv
// Far-side CAN node model: accepts offered frames and injects frames
`timescale 1ns/100ps
`default_nettype none
module cmo_can_node
  import cmo_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic txValid,
  input wire cmo_frame_t txFrame,
  input wire logic [3:0] lag,
  output logic txDone,
  output logic rxValid,
  output cmo_frame_t rxFrame,
  output cmo_frame_t seenFrame,
  output logic [7:0] seenCount
);
  logic [3:0] waitCnt;

  // Acknowledge each offered frame after lag cycles, keep a copy
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txDone <= 1'b0;
      waitCnt <= 4'h0;
      seenCount <= 8'h00;
      seenFrame <= '0;
    end else begin
      txDone <= 1'b0;
      if (txValid && !txDone) begin
        if (waitCnt == lag) begin
          txDone <= 1'b1;
          waitCnt <= 4'h0;
          seenFrame <= txFrame;
          seenCount <= seenCount + 8'h01;
        end else begin
          waitCnt <= waitCnt + 4'h1;
        end
      end
    end
  end

  // Idle bus starts at zero; after a send it shows inverted junk, never the last frame
  initial begin
    rxValid = 1'b0;
    rxFrame = '0;
  end

  // One-cycle delivery of a complete received frame
  task automatic send(input cmo_frame_t f);
    @(posedge clk);
    rxValid <= 1'b1;
    rxFrame <= f;
    @(posedge clk);
    rxValid <= 1'b0;
    rxFrame <= ~f;
  endtask
endmodule
`default_nettype wire

// ### verification/cmo_message_objects_tb.sv
// Self-checking bench for the CAN message object block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    errTotal++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module cmo_message_objects_tb
  import cmo_pkg::*;
;
  logic clk;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, rxValid, txValid, txDone, irq;
  cmo_frame_t rxFrame, txFrame, seen;
  logic [7:0] auxIn, auxOut, auxOe, seenCount, dir, out, ext = 8'h0C;
  logic [3:0] lag = 4'h0;
  logic [10:0] idA, idC, idL;
  logic [28:0] idB;
  logic [63:0] dA, dB, dC;
  integer seed = 93;
  int errTotal = 0, compares = 0;
  logic [7:0] rstA [6] = '{ADDR_GMASK_STD, ADDR_GMASK_EXT, ADDR_MASK_LAST,
    ADDR_AUX_OUT, ADDR_AUX_DIR, ADDR_INT_MASK};
  logic [31:0] rstV [6] = '{32'(GMASK_STD_RST), 32'(GMASK_EXT_RST),
    32'(MASK_LAST_RST), 32'(AUX_OUT_RST), 32'(AUX_DIR_RST), INT_MASK_RST};

  // Pin level: driven value, else pull-up or bench value
  assign auxIn = (auxOe & auxOut) | (~auxOe & ext);

  cmo_message_objects dut_u (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxValid(rxValid), .rxFrame(rxFrame), .txValid(txValid),
    .txFrame(txFrame), .txDone(txDone), .auxIn(auxIn), .auxOut(auxOut),
    .auxOe(auxOe), .irq(irq));

  cmo_can_node node_u (.clk(clk), .rst_b(rst_b), .txValid(txValid),
    .txFrame(txFrame), .lag(lag), .txDone(txDone), .rxValid(rxValid),
    .rxFrame(rxFrame), .seenFrame(seen), .seenCount(seenCount));

  // Clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Expected pin enables for a direction and output setting
  function automatic logic [7:0] oeOf(logic [7:0] d, logic [7:0] o);
    return {d[7:4], ~o[3:2], d[1:0]};
  endfunction

  function automatic cmo_frame_t mk(logic x, logic t, logic [28:0] i,
    logic [63:0] d);
    return '{x, t, i, 4'h8, d};
  endfunction

  // APB transfer; answer taken at the rising edge where pready is high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) errTotal++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // Program one object: select, identifier, data, control
  task automatic cfg(input logic [3:0] o, input logic x,
    input logic [10:0] i, input logic [31:0] c, input logic [63:0] d);
    wr(ADDR_OBJ_SEL, {28'h0, o});
    wr(ADDR_OBJ_ID, {x, 20'h0, i});
    wr(ADDR_OBJ_DLO, d[31:0]);
    wr(ADDR_OBJ_DHI, d[63:32]);
    wr(ADDR_OBJ_CTRL, c);
  endtask

  task automatic stat(input logic [31:0] x);
    rd(ADDR_INT_STAT);
    `CHK(r, x)
  endtask

  task automatic waitTx(input logic [7:0] n);
    for (int k = 0; k < 400 && seenCount !== n; k++) @(posedge clk);
  endtask

  task automatic results();
    $display("compares=%0d errors=%0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge clk);
    errTotal++;
    results();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    idA = {1'b0, 10'($random(seed))};
    idC = idA ^ 11'h100;
    idL = {1'b1, 6'($random(seed)), 4'h0};
    idB = {18'($random(seed)), idA};
    dA = {$random(seed), $random(seed)};
    dB = {$random(seed), $random(seed)};
    dC = {$random(seed), $random(seed)};
    // Reset values, released pins, unmapped offset
    for (int i = 0; i < 6; i++) begin
      rd(rstA[i]);
      `CHK(r, rstV[i])
    end
    `CHK(auxOe, 8'h00)
    rd(8'hFC);
    `CHK(e, 1'b1)
    // Twin receivers, extended receiver, transmitter, last object
    cfg(4'h0, 1'b0, idA, 32'h81, 64'h0);
    cfg(4'h3, 1'b0, idA, 32'h81, 64'h0);
    cfg(4'h1, 1'b1, idB[10:0], 32'h81, 64'h0);
    wr(ADDR_OBJ_ID, {1'b1, 2'b00, idB});
    cfg(4'h2, 1'b0, idC, 32'h83, dC);
    cfg(4'hE, 1'b0, idL, 32'h83, 64'h0);
    rd(ADDR_OBJ_CTRL);
    `CHK(r[1:0], 2'b01)
    wr(ADDR_MASK_LAST, 32'h7F0);
    // Lowest matching object takes the frame, irq masked
    node_u.send(mk(1'b0, 1'b0, {18'h0, idA}, dA));
    stat(32'h1);
    @(negedge clk);
    `CHK(irq, 1'b0)
    wr(ADDR_OBJ_SEL, 32'h0);
    rd(ADDR_OBJ_DLO);
    `CHK(r, dA[31:0])
    rd(ADDR_OBJ_DHI);
    `CHK(r, dA[63:32])
    wr(ADDR_INT_MASK, 32'h7FFF7FFF);
    rd(ADDR_INT_MASK);
    `CHK(r, 32'h7FFF7FFF)
    @(negedge clk);
    `CHK(irq, 1'b1)
    wr(ADDR_INT_STAT, 32'h1);
    rd(ADDR_INT_STAT);
    @(negedge clk);
    `CHK(irq, 1'b0)
    // Extended frame, then global masks
    node_u.send(mk(1'b1, 1'b0, idB, dB));
    stat(32'h2);
    wr(ADDR_INT_STAT, 32'h2);
    wr(ADDR_GMASK_STD, 32'h7FE);
    node_u.send(mk(1'b0, 1'b0, {18'h0, idA ^ 11'h1}, dB));
    stat(32'h1);
    wr(ADDR_INT_STAT, 32'h1);
    node_u.send(mk(1'b1, 1'b0, idB ^ 29'h1, dB));
    stat(32'h0);
    // Last object: local mask, held frame, overrun, promotion
    node_u.send(mk(1'b0, 1'b0, {18'h0, idL | 11'h3}, dA));
    stat(32'h4000);
    node_u.send(mk(1'b0, 1'b0, {18'h0, idL | 11'h9}, dB));
    node_u.send(mk(1'b0, 1'b0, {18'h0, idL | 11'h5}, dC));
    rd(ADDR_LAST_STAT);
    `CHK(r[1:0], 2'b11)
    rd(ADDR_LAST_ID);
    `CHK(r[10:0], idL | 11'h3)
    wr(ADDR_INT_STAT, 32'h4000);
    stat(32'h4000);
    rd(ADDR_LAST_ID);
    `CHK(r[10:0], idL | 11'h5)
    wr(ADDR_LAST_STAT, 32'h2);
    rd(ADDR_LAST_STAT);
    `CHK(r[1:0], 2'b00)
    wr(ADDR_INT_STAT, 32'h4000);
    // Receive object requests data, slow far side
    lag <= 4'h5;
    wr(ADDR_OBJ_CTRL, 32'h85);
    waitTx(8'h1);
    `CHK(seenCount, 8'h1)
    `CHK(seen.rtr, 1'b1)
    `CHK(seen.id[10:0], idA)
    stat(32'h10000);
    wr(ADDR_INT_STAT, 32'h10000);
    // Transmit object answers a remote frame, prompt far side
    lag <= 4'h0;
    node_u.send(mk(1'b0, 1'b1, {18'h0, idC}, 64'h0));
    waitTx(8'h2);
    `CHK(seenCount, 8'h2)
    `CHK(seen.rtr, 1'b0)
    `CHK(seen.data, dC)
    rd(ADDR_INT_STAT);
    `CHK(r[18], 1'b1)
    // Port: user lines, open-drain serial pair, pin readback
    wr(ADDR_CTRL, 32'h0);
    repeat (4) begin
      dir = 8'($random(seed));
      out = 8'($random(seed));
      @(posedge clk);
      ext <= {4'($random(seed)), 2'b11, 2'($random(seed))};
      wr(ADDR_AUX_DIR, {24'h0, dir});
      wr(ADDR_AUX_OUT, {24'h0, out});
      repeat (2) @(negedge clk);
      `CHK(auxOe, oeOf(dir, out))
      `CHK(auxOut, {out[7:4], 2'b00, out[1:0]})
      repeat (3) @(posedge clk);
      rd(ADDR_AUX_IN);
      `CHK(r[7:0], (oeOf(dir, out) & out) | (~oeOf(dir, out) & ext))
    end
    wr(ADDR_CTRL, 32'h1);
    repeat (2) @(negedge clk);
    `CHK(auxOut[1:0], 2'b01)
    `CHK(auxOe[1:0], 2'h3)
    results();
  end
endmodule
`default_nettype wire
